// ---- bench/dcdac_bus_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcdac_bus_master (
   // Clock
   input  wire logic mclk_in,
   // Bus pins
   input  wire logic sda_in,
   output var  logic scl_out,
   output var  logic sda_oe_out
);
   int lo_cyc = 65;
   int hi_cyc = 60;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic wait_c(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   // ----------------------------------------------------------------
   // Bit, byte and framing
   // ----------------------------------------------------------------
   task automatic bit_x(input logic b, output logic v);
      wait_c(4);
      sda_oe_out = !b;
      wait_c(lo_cyc);
      scl_out = 1'b1;
      wait_c(hi_cyc);
      v = sda_in;
      scl_out = 1'b0;
   endtask
   task automatic start_c();
      sda_oe_out = 1'b1;
      wait_c(hi_cyc);
      scl_out = 1'b0;
   endtask
   task automatic stop_c();
      wait_c(4);
      sda_oe_out = 1'b1;
      wait_c(lo_cyc);
      scl_out = 1'b1;
      wait_c(hi_cyc);
      sda_oe_out = 1'b0;
      wait_c(lo_cyc);
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--) bit_x(b[i], v);
      bit_x(1'b1, ack);
   endtask
   task automatic get(input logic nak, output logic [7:0] b);
      logic v;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
      bit_x(nak, v);
   endtask
endmodule
`default_nettype wire

// ---- bench/dcdac_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcdac_top_bench;
   logic                  mclk = 1'b0;
   logic                  reset = 1'b1;
   logic                  scl, m_oe, dev_oe, dev_sda, ack;
   wire                   sda = dev_oe ? (dev_sda && !m_oe) : !m_oe;
   dcdac_pkg::dcdac_out_s o0, o1;
   logic [7:0]            rd, d, reg0 = 8'h00, reg1 = 8'h00, last_ma = 8'h00;
   logic [17:0]           last = '0;
   logic [17:0]           q[$];
   logic [7:0]            tbl[6] = '{8'h80, 8'h7f, 8'hff,
                                     8'h01, 8'h00, 8'h81};
   int                    fails = 0;
   int                    n_checks = 0;
   always #10 mclk = ~mclk;
   dcdac_top i_dcdac_top (.mclk_in(mclk), .reset_in(reset), .scl_in(scl),
      .sda_in(sda), .sda_out(dev_sda), .sda_oe_out(dev_oe),
      .first_current_output_out(o0), .second_current_output_out(o1));
   dcdac_bus_master i_m (.mclk_in(mclk), .sda_in(sda), .scl_out(scl),
      .sda_oe_out(m_oe));
   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [8:0] outv(input logic [7:0] r);
      return {!r[7] && r[6:0] != 7'h00, r[7] && r[6:0] != 7'h00, r[6:0]};
   endfunction
   task automatic note(input logic [7:0] a, input logic [7:0] b);
      if ({outv(a), outv(b)} != {outv(reg0), outv(reg1)})
         q.push_back({outv(a), outv(b)});
      reg0 = a;
      reg1 = b;
   endtask
   always @(negedge mclk) begin
      if ({o0, o1} !== last) begin
         if (q.size() == 0) check({o0, o1}, last);
         else check({o0, o1}, q.pop_front());
         last = {o0, o1};
      end
   end
   task automatic wr(input logic [7:0] sa, ma, dat);
      logic nak;
      nak = (sa != 8'h90);
      i_m.start_c();
      i_m.put(sa, ack);
      check(ack, nak);
      i_m.put(ma, ack);
      check(ack, nak);
      if (!nak) begin
         note(ma == 8'hf8 ? dat : reg0, ma == 8'hf9 ? dat : reg1);
         last_ma = ma;
      end
      i_m.put(dat, ack);
      check(ack, nak);
      i_m.stop_c();
   endtask
   task automatic rd_chk();
      i_m.start_c();
      i_m.put(8'h91, ack);
      check(ack, 1'b0);
      i_m.get(1'b1, rd);
      check(rd, last_ma == 8'hf9 ? reg1 : reg0);
      i_m.stop_c();
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'had1dfadf));
      repeat (8) @(negedge mclk);
      reset = 1'b0;
      repeat (2) @(negedge mclk);
      check({o0, o1}, 18'h0);
      rd_chk();
      $display("reset values done");
      wr(8'h90, 8'hf8, 8'haa);
      rd_chk();
      for (int i = 0; i < 10; i++) begin
         d = i < 6 ? tbl[i] : 8'($urandom);
         wr(8'h90, i[0] ? 8'hf9 : 8'hf8, d);
      end
      rd_chk();
      $display("register writes done");
      wr(8'h90, 8'($urandom) & 8'hf7, 8'h55);
      wr(8'h92, 8'hf8, 8'h55);
      rd_chk();
      $display("refused writes done");
      i_m.lo_cyc = 235;
      i_m.hi_cyc = 200;
      wr(8'h90, 8'hf9, 8'h3c);
      i_m.lo_cyc = 65;
      i_m.hi_cyc = 60;
      rd_chk();
      $display("slow bus done");
      note(8'h00, 8'h00);
      last_ma = 8'h00;
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      repeat (2) @(negedge mclk);
      rd_chk();
      check(18'(q.size()), 18'h0);
      $display("second reset done");
      print_verdict();
   end
   initial begin
      // About 77k cycles expected; limit at 90k cycles
      #1_800_000;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- bench/dcdac_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcdac_top_sva (
   // Clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 reset_in,
   // Serial bus
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   input  wire logic                 sda_out,
   input  wire logic                 sda_oe_out,
   // Current outputs
   input  wire dcdac_pkg::dcdac_out_s first_current_output_out,
   input  wire dcdac_pkg::dcdac_out_s second_current_output_out
);
   wire dcdac_pkg::dcdac_out_s f = first_current_output_out;
   wire dcdac_pkg::dcdac_out_s s = second_current_output_out;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_reset_clear:
      assert property ($fell(reset_in) |-> f == '0 && s == '0)
      else $error("outputs not zero after reset");
   a_zero_first_idle:
      assert property (f.magnitude_field == 7'h00 |-> !f.sink_active
         && !f.source_active) else $error("first flags set at zero");
   a_zero_second_idle:
      assert property (s.magnitude_field == 7'h00 |-> !s.sink_active
         && !s.source_active) else $error("second flags set at zero");
   a_one_flag_first:
      assert property (f.magnitude_field != 7'h00 |-> f.sink_active
         ^ f.source_active) else $error("first flags wrong");
   a_one_flag_second:
      assert property (s.magnitude_field != 7'h00 |-> s.sink_active
         ^ s.source_active) else $error("second flags wrong");
   a_one_reg_write:
      assert property (!($changed(f) && $changed(s)))
      else $error("both outputs changed together");
   a_update_scl_high:
      assert property (($changed(f) || $changed(s)) |-> scl_in)
      else $error("output changed with clock low");
   a_open_drain_low:
      assert property (sda_oe_out |-> !sda_out)
      else $error("data driven high");
   a_ack_hold:
      assert property ($rose(sda_oe_out) |-> sda_oe_out [*3])
      else $error("data pulse too short");
   a_sda_move_low:
      assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data moved while clock high");
   a_stop_release:
      assert property (scl_in && $past(scl_in) && $rose(sda_in) |=>
         !sda_oe_out) else $error("data held after stop");
   c_source_first: cover property ($rose(f.source_active));
   c_sink_second: cover property ($rose(s.sink_active));
   c_ack: cover property ($rose(sda_oe_out));
endmodule
bind dcdac_top dcdac_top_sva i_dcdac_top_sva (
   .mclk_in                   (mclk_in),
   .reset_in                  (reset_in),
   .scl_in                    (scl_in),
   .sda_in                    (sda_in),
   .sda_out                   (sda_out),
   .sda_oe_out                (sda_oe_out),
   .first_current_output_out  (first_current_output_out),
   .second_current_output_out (second_current_output_out)
);
`default_nettype wire

// ---- hdl/dcdac_ctrl_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcdac_ctrl_regs (
   // Clock and reset
   input  wire  logic                       mclk_in,
   input  wire  logic                       reset_in,
   // Write port
   input  wire  logic                       wr_en_in,
   input  wire  logic [7:0]                 wr_addr_in,
   input  wire  logic [7:0]                 wr_data_in,
   // Read port
   input  wire  logic                       rd_sel_in,
   output logic [7:0]                       rd_data_out,
   // Stored settings
   output dcdac_pkg::dcdac_ctrl_s [1:0]     ctrl_out
);
   logic [7:0] mem_reg [2];
   logic [7:0] rd_data_reg;
   logic       hit [2];

   assign hit[0] = wr_en_in && (wr_addr_in == dcdac_pkg::ADDR_FIRST);
   assign hit[1] = wr_en_in && (wr_addr_in == dcdac_pkg::ADDR_SECOND);

   genvar g;
   generate
      for (g = 0; g < dcdac_pkg::NUM_OUTPUTS; g++) begin : gen_reg
         always_ff @(posedge mclk_in or posedge reset_in) begin
            if (reset_in) begin
               mem_reg[g] <= dcdac_pkg::CTRL_RESET;
            end else if (hit[g]) begin
               mem_reg[g] <= wr_data_in;
            end
         end
         assign ctrl_out[g] = dcdac_pkg::dcdac_ctrl_s'(mem_reg[g]);
      end
   endgenerate

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_data_reg <= dcdac_pkg::CTRL_RESET;
      end else begin
         rd_data_reg <= rd_sel_in ? mem_reg[1] : mem_reg[0];
      end
   end
   assign rd_data_out = rd_data_reg;
endmodule
`default_nettype wire

// ---- hdl/dcdac_pkg.sv ----
package dcdac_pkg;

   // ----------------------------------------------------------------
   // Bus addressing
   // ----------------------------------------------------------------
   localparam logic [6:0] SLAVE_ADDR     = 7'h48;
   localparam logic [7:0] ADDR_FIRST     = 8'hf8;
   localparam logic [7:0] ADDR_SECOND    = 8'hf9;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam int         NUM_OUTPUTS    = 2;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int         POL_BIT        = 7;
   localparam int         MAG_MSB        = 6;
   localparam logic [6:0] MAG_ZERO       = 7'h00;
   localparam logic [6:0] MAG_FULL       = 7'h7f;
   localparam logic [2:0] BIT_LAST       = 3'h7;
   localparam logic [2:0] BIT_FIRST      = 3'h0;

   // ----------------------------------------------------------------
   // Bus timing
   // ----------------------------------------------------------------
   localparam int         SCL_MAX_KHZ    = 400;
   localparam int         CLK_KHZ        = 50000;
   localparam int         SCL_MIN_CYC    = CLK_KHZ / SCL_MAX_KHZ;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_SADDR = 6'h02,
      ST_ACK   = 6'h04,
      ST_RX    = 6'h08,
      ST_TX    = 6'h10,
      ST_MACK  = 6'h20
   } dcdac_state_e;

   typedef enum logic [1:0] {
      PH_ADDR = 2'h0,
      PH_MEM  = 2'h1,
      PH_DATA = 2'h2,
      PH_DONE = 2'h3
   } dcdac_phase_e;

   typedef struct packed {
      logic       source;
      logic [6:0] magnitude_field;
   } dcdac_ctrl_s;

   typedef struct packed {
      logic       sink_active;
      logic       source_active;
      logic [6:0] magnitude_field;
   } dcdac_out_s;

endpackage

// ---- hdl/dcdac_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Two control registers at memory addresses f8 and f9, bus writable.
// - Each register: polarity in bit 7, magnitude in bits 6 to 0.
// - Polarity 0 sinks current, polarity 1 sources current.
// - Zero magnitude gives no current regardless of polarity.
// - Both registers come out of reset holding zero.
// - Current equals magnitude over 127 of full scale.
// - Bus runs from zero up to fast-mode rate, standard mode too.
// - Memory address is always the second byte of a write.
// - Non-matching slave address: ignore bus until next start.
module dcdac_top (
   // Clock and reset
   input  wire  logic              mclk_in,
   input  wire  logic              reset_in,
   // Serial bus
   input  wire  logic              scl_in,
   input  wire  logic              sda_in,
   output logic                    sda_out,
   output logic                    sda_oe_out,
   // Current outputs
   output dcdac_pkg::dcdac_out_s   first_current_output_out,
   output dcdac_pkg::dcdac_out_s   second_current_output_out
);
   // ----------------------------------------------------------------
   // Bus line sampling and conditions
   // ----------------------------------------------------------------
   logic scl_reg;
   logic sda_reg;
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         scl_reg <= scl_in;
         sda_reg <= sda_in;
      end
   end

   // Edge detection on the sampled lines, no SCL rate floor
   wire scl_rise = scl_in && !scl_reg;
   wire scl_fall = !scl_in && scl_reg;
   wire start_c  = scl_in && scl_reg && sda_reg && !sda_in;
   wire stop_c   = scl_in && scl_reg && !sda_reg && sda_in;

   // ----------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------
   dcdac_pkg::dcdac_state_e state_reg;
   dcdac_pkg::dcdac_state_e state_next;
   dcdac_pkg::dcdac_phase_e phase_reg;
   dcdac_pkg::dcdac_phase_e phase_next;
   logic [2:0] bit_reg;
   logic [2:0] bit_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [7:0] mem_addr_reg;
   logic [7:0] mem_addr_next;
   logic       rd_mode_reg;
   logic       rd_mode_next;
   logic       ack_drv_reg;
   logic       ack_drv_next;
   logic       sda_out_reg;
   logic       sda_out_next;
   logic       wr_en;
   logic [7:0] rd_data;

   wire [7:0] shifted  = {shift_reg[6:0], sda_in};
   wire       addr_hit = shifted[7:1] == dcdac_pkg::SLAVE_ADDR;
   wire       rd_sel   = mem_addr_reg == dcdac_pkg::ADDR_SECOND;

   always_comb begin
      state_next    = state_reg;
      phase_next    = phase_reg;
      bit_next      = bit_reg;
      shift_next    = shift_reg;
      mem_addr_next = mem_addr_reg;
      rd_mode_next  = rd_mode_reg;
      ack_drv_next  = ack_drv_reg;
      sda_out_next  = sda_out_reg;
      wr_en         = 1'b0;
      if (start_c) begin
         state_next   = dcdac_pkg::ST_SADDR;
         phase_next   = dcdac_pkg::PH_ADDR;
         bit_next     = dcdac_pkg::BIT_FIRST;
         ack_drv_next = 1'b0;
      end else if (stop_c) begin
         state_next   = dcdac_pkg::ST_IDLE;
         ack_drv_next = 1'b0;
      end else begin
         case (state_reg)
            dcdac_pkg::ST_IDLE: begin
               ack_drv_next = 1'b0;
            end
            dcdac_pkg::ST_SADDR, dcdac_pkg::ST_RX: begin
               if (scl_rise) begin
                  shift_next = shifted;
                  bit_next   = bit_reg + 3'h1;
                  if (bit_reg == dcdac_pkg::BIT_LAST) begin
                     if (state_reg == dcdac_pkg::ST_SADDR) begin
                        if (addr_hit) begin
                           rd_mode_next = shifted[0];
                           state_next   = dcdac_pkg::ST_ACK;
                           phase_next   = shifted[0] ? dcdac_pkg::PH_DONE
                                                     : dcdac_pkg::PH_MEM;
                        end else begin
                           state_next = dcdac_pkg::ST_IDLE;
                        end
                     end else if (phase_reg == dcdac_pkg::PH_MEM) begin
                        mem_addr_next = shifted;
                        phase_next    = dcdac_pkg::PH_DATA;
                        state_next    = dcdac_pkg::ST_ACK;
                     end else if (phase_reg == dcdac_pkg::PH_DATA) begin
                        wr_en      = 1'b1;
                        phase_next = dcdac_pkg::PH_DONE;
                        state_next = dcdac_pkg::ST_ACK;
                     end else begin
                        state_next = dcdac_pkg::ST_ACK;
                     end
                  end
               end
            end
            dcdac_pkg::ST_ACK: begin
               // Drive ack low through the ninth clock
               if (scl_fall && !ack_drv_reg) begin
                  ack_drv_next = 1'b1;
                  sda_out_next = 1'b0;
               end else if (scl_fall && ack_drv_reg) begin
                  ack_drv_next = 1'b0;
                  bit_next     = dcdac_pkg::BIT_FIRST;
                  if (rd_mode_reg) begin
                     state_next   = dcdac_pkg::ST_TX;
                     ack_drv_next = 1'b1;
                     sda_out_next = rd_data[dcdac_pkg::POL_BIT];
                     shift_next   = {rd_data[6:0], 1'b0};
                  end else begin
                     state_next = dcdac_pkg::ST_RX;
                  end
               end
            end
            dcdac_pkg::ST_TX: begin
               if (scl_fall) begin
                  bit_next = bit_reg + 3'h1;
                  if (bit_reg == dcdac_pkg::BIT_LAST) begin
                     ack_drv_next = 1'b0;
                     state_next   = dcdac_pkg::ST_MACK;
                  end else begin
                     sda_out_next = shift_reg[7];
                     shift_next   = {shift_reg[6:0], 1'b0};
                  end
               end
            end
            dcdac_pkg::ST_MACK: begin
               // Master nack ends the read; ack repeats the byte
               if (scl_rise) begin
                  if (sda_in) begin
                     state_next = dcdac_pkg::ST_IDLE;
                  end else begin
                     // Armed but released, so no low pulse with clock high
                     state_next   = dcdac_pkg::ST_ACK;
                     ack_drv_next = 1'b1;
                     sda_out_next = 1'b1;
                  end
               end
            end
            default: begin
               state_next   = dcdac_pkg::ST_IDLE;
               ack_drv_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg    <= dcdac_pkg::ST_IDLE;
         phase_reg    <= dcdac_pkg::PH_ADDR;
         bit_reg      <= dcdac_pkg::BIT_FIRST;
         shift_reg    <= dcdac_pkg::CTRL_RESET;
         mem_addr_reg <= dcdac_pkg::CTRL_RESET;
         rd_mode_reg  <= 1'b0;
         ack_drv_reg  <= 1'b0;
         sda_out_reg  <= 1'b1;
      end else begin
         state_reg    <= state_next;
         phase_reg    <= phase_next;
         bit_reg      <= bit_next;
         shift_reg    <= shift_next;
         mem_addr_reg <= mem_addr_next;
         rd_mode_reg  <= rd_mode_next;
         ack_drv_reg  <= ack_drv_next;
         sda_out_reg  <= sda_out_next;
      end
   end

   assign sda_out    = sda_out_reg;
   assign sda_oe_out = ack_drv_reg && !sda_out_reg;

   // ----------------------------------------------------------------
   // Control registers and output decode
   // ----------------------------------------------------------------
   dcdac_pkg::dcdac_ctrl_s [1:0] ctrl;

   dcdac_ctrl_regs i_dcdac_ctrl_regs (
      .mclk_in     (mclk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_en),
      .wr_addr_in  (mem_addr_reg),
      .wr_data_in  (shifted),
      .rd_sel_in   (rd_sel),
      .rd_data_out (rd_data),
      .ctrl_out    (ctrl)
   );

   dcdac_pkg::dcdac_out_s out_reg [2];
   genvar g;
   generate
      for (g = 0; g < dcdac_pkg::NUM_OUTPUTS; g++) begin : gen_out
         // Magnitude out of 127 steps of full scale
         wire nz = ctrl[g].magnitude_field != dcdac_pkg::MAG_ZERO;
         always_ff @(posedge mclk_in or posedge reset_in) begin
            if (reset_in) begin
               out_reg[g] <= '0;
            end else begin
               out_reg[g].sink_active     <= nz && !ctrl[g].source;
               out_reg[g].source_active   <= nz && ctrl[g].source;
               out_reg[g].magnitude_field <= ctrl[g].magnitude_field;
            end
         end
      end
   endgenerate

   assign first_current_output_out  = out_reg[0];
   assign second_current_output_out = out_reg[1];
endmodule
`default_nettype wire
